/* hw/tsts_pkg.sv */
package tsts_pkg;
	localparam int         WORD_W      = 10;
	localparam int         FIFO_DEPTH  = 8;
	localparam int         PRBS_W      = 7;
	localparam logic [6:0] PRBS_SEED   = 7'h7f;
	localparam logic [6:0] COMMA_PAT   = 7'h7c;
	localparam logic [3:0] LAST_BIT    = 4'h9;
	localparam logic [3:0] EDGE_BIT    = 4'h4;
	localparam logic [3:0] ALIGN_BIT   = 4'h6;
	localparam logic [3:0] ALIGN_NEXT  = 4'h7;
	localparam logic [2:0] WARM_BITS   = 3'h7;
	localparam logic [4:0] FULL_MIN_M1 = 5'h04;
	localparam logic [4:0] HALF_MIN_M1 = 5'h09;
	localparam logic [4:0] PH_MAX      = 5'h1f;
	localparam logic [9:0] IDLE_WORD   = 10'h000;

	typedef struct packed {
		logic enable;
		logic loopback;
		logic prbs;
		logic align;
		logic rate;
	} tsts_cfg_t;
endpackage : tsts_pkg

/* hw/tsts_top.sv */
`timescale 1ns/1ps
module tsts_sync
	import tsts_pkg::*;
#(
	parameter int W = 1
)
(
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;

	// A change counts once stages two and three agree
	genvar i;
	for (i = 0; i < W; i++)
	begin : g_bit
		always_ff @(posedge clk)
		begin
			s1_reg[i] <= d[i];
			s2_reg[i] <= s1_reg[i];
			s3_reg[i] <= s2_reg[i];
			if (!rst_n)
				q[i] <= 1'b0;
			else if (s2_reg[i] == s3_reg[i])
				q[i] <= s3_reg[i];
		end
	end
endmodule : tsts_sync

module tsts_fifo
	import tsts_pkg::*;
#(
	parameter int W = WORD_W,
	parameter int D = FIFO_DEPTH
)
(
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	output logic              out_valid,
	output logic      [W-1:0] out_data,
	input  wire logic         out_ready
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wp_reg;
	logic [AW-1:0] rp_reg;
	logic [AW:0]   cnt_reg;
	logic [AW:0]   cnt_next;
	wire           push = in_valid & in_ready;
	wire           pop  = out_valid & out_ready;

	assign cnt_next  = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	assign out_valid = cnt_reg != '0;
	assign out_data  = mem[rp_reg];

	always_ff @(posedge clk)
		if (push)
			mem[wp_reg] <= in_data;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wp_reg   <= '0;
			rp_reg   <= '0;
			cnt_reg  <= '0;
			in_ready <= 1'b0;
		end
		else
		begin
			wp_reg   <= wp_reg + AW'(push);
			rp_reg   <= rp_reg + AW'(pop);
			cnt_reg  <= cnt_next;
			in_ready <= cnt_next != (AW+1)'(D);
		end
	end
endmodule : tsts_fifo

module tsts_top
	import tsts_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic              serial_clk,
	input  wire logic              enable,
	input  wire logic              loopback_enable,
	input  wire logic              prbs_test_enable,
	input  wire logic              comma_align_enable,
	input  wire logic              rx_clock_rate_select,
	input  wire logic [WORD_W-1:0] tx_parallel_word,
	input  wire logic              tx_word_valid,
	output logic                   tx_word_ready,
	input  wire logic              serial_rx_pos,
	input  wire logic              serial_rx_neg,
	output logic                   serial_tx_pos,
	output logic                   serial_tx_neg,
	output logic                   serial_tx_oe,
	output logic      [WORD_W-1:0] rx_parallel_word,
	output logic                   rx_byte_clock_a,
	output logic                   rx_byte_clock_b,
	output logic                   rx_out_oe,
	output logic                   sync_or_pass_flag,
	output logic                   input_pull_enable
);
	function automatic logic [PRBS_W+WORD_W-1:0] prbs_step(input logic [PRBS_W-1:0] s_in);
		logic [PRBS_W-1:0] s;
		logic [WORD_W-1:0] w;
		s = s_in;
		w = '0;
		for (int k = 0; k < WORD_W; k++)
		begin
			w[k] = s[6] ^ s[5];
			s    = {s[5:0], w[k]};
		end
		return {s, w};
	endfunction : prbs_step

	tsts_cfg_t cfg_pins;
	tsts_cfg_t cfg_c;
	tsts_cfg_t cfg_l;
	assign cfg_pins = '{enable: enable, loopback: loopback_enable, prbs: prbs_test_enable,
		align: comma_align_enable, rate: rx_clock_rate_select};

	// Reference clock domain: capture, pattern source, FIFO, word handshake
	tsts_sync #(.W($bits(tsts_cfg_t))) u_sync_c (
		.clk   (clk),
		.rst_n (nrst),
		.d     (cfg_pins),
		.q     (cfg_c)
	);
	wire crun = nrst & cfg_c.enable;
	assign input_pull_enable = cfg_c.enable;

	logic [PRBS_W-1:0] gen_state_reg;
	logic [WORD_W-1:0] hs_data_reg;
	logic              hs_req_reg;
	logic              ack_s1_reg;
	logic              ack_s2_reg;
	logic              ack_reg;
	logic [WORD_W-1:0] fifo_out;
	logic              fifo_out_valid;
	wire [PRBS_W+WORD_W-1:0] gen_step = prbs_step(gen_state_reg);
	wire [WORD_W-1:0] gen_word   = gen_step[WORD_W-1:0];
	wire [WORD_W-1:0] fifo_in    = cfg_c.prbs ? gen_word : tx_parallel_word;
	wire              fifo_in_v  = cfg_c.prbs | tx_word_valid;
	wire              hs_idle    = ack_s2_reg == hs_req_reg;
	wire              fifo_pop   = fifo_out_valid & hs_idle;
	wire              gen_adv    = cfg_c.prbs & tx_word_ready;

	tsts_fifo #(.W(WORD_W), .D(FIFO_DEPTH)) u_fifo (
		.clk       (clk),
		.rst_n     (crun),
		.in_valid  (fifo_in_v),
		.in_data   (fifo_in),
		.in_ready  (tx_word_ready),
		.out_valid (fifo_out_valid),
		.out_data  (fifo_out),
		.out_ready (hs_idle)
	);

	always_ff @(posedge clk)
	begin
		ack_s1_reg <= ack_reg;
		ack_s2_reg <= ack_s1_reg;
		if (!crun)
		begin
			gen_state_reg <= PRBS_SEED;
			hs_req_reg    <= 1'b0;
			hs_data_reg   <= IDLE_WORD;
		end
		else
		begin
			if (gen_adv)
				gen_state_reg <= gen_step[PRBS_W+WORD_W-1:WORD_W];
			if (fifo_pop)
			begin
				hs_data_reg <= fifo_out;
				hs_req_reg  <= ~hs_req_reg;
			end
		end
	end

	// Link clock domain: serializer, receiver, checker, byte clocks
	logic lrst_s1_reg;
	logic lrst_s2_reg;
	always_ff @(posedge serial_clk)
	begin
		lrst_s1_reg <= nrst;
		lrst_s2_reg <= lrst_s1_reg;
	end
	tsts_sync #(.W($bits(tsts_cfg_t))) u_sync_l (
		.clk   (serial_clk),
		.rst_n (lrst_s2_reg),
		.d     (cfg_pins),
		.q     (cfg_l)
	);
	wire lrun = lrst_s2_reg & cfg_l.enable;

	logic              req_s1_reg;
	logic              req_s2_reg;
	logic [3:0]        scnt_reg;
	logic [WORD_W-1:0] sh_reg;
	wire               tx_last  = scnt_reg == LAST_BIT;
	wire               word_new = req_s2_reg != ack_reg;
	wire [WORD_W-1:0]  ld_word  = word_new ? hs_data_reg : IDLE_WORD;
	wire [WORD_W-1:0]  sh_next  = tx_last ? ld_word : {1'b0, sh_reg[WORD_W-1:1]};

	always_ff @(posedge serial_clk)
	begin
		req_s1_reg <= hs_req_reg;
		req_s2_reg <= req_s1_reg;
		if (!lrun)
		begin
			scnt_reg      <= LAST_BIT;
			sh_reg        <= IDLE_WORD;
			ack_reg       <= 1'b0;
			serial_tx_pos <= 1'b0;
			serial_tx_neg <= 1'b0;
			serial_tx_oe  <= 1'b0;
		end
		else
		begin
			scnt_reg      <= tx_last ? 4'h0 : scnt_reg + 4'h1;
			sh_reg        <= sh_next;
			ack_reg       <= ack_reg ^ (tx_last & word_new);
			serial_tx_pos <= sh_next[0];
			serial_tx_neg <= ~sh_next[0];
			serial_tx_oe  <= ~cfg_l.loopback;
		end
	end

	logic              rxin_reg;
	logic [6:0]        win_reg;
	logic [WORD_W-1:0] wsh_reg;
	logic [3:0]        bcnt_reg;
	logic              par_reg;
	logic [6:0]        chk_reg;
	logic [2:0]        warm_reg;
	logic              prbs_d_reg;
	logic [4:0]        ph_reg;
	logic              rbc_a_next;
	logic              rbc_b_next;
	logic              flag_next;
	wire               rx_pin   = serial_rx_pos & ~serial_rx_neg;
	wire [6:0]         win_next = {rxin_reg, win_reg[6:1]};
	wire [WORD_W-1:0]  wsh_next = {rxin_reg, wsh_reg[WORD_W-1:1]};
	wire               comma    = cfg_l.align & ~cfg_l.prbs & (win_next == COMMA_PAT);
	wire               realign  = comma & (bcnt_reg != ALIGN_BIT);
	wire               rx_last  = (bcnt_reg == LAST_BIT) & ~realign;
	wire               edge_pt  = bcnt_reg == EDGE_BIT;
	wire [4:0]         min_ph   = cfg_l.rate ? FULL_MIN_M1 : HALF_MIN_M1;
	wire               ph_ok    = ph_reg >= min_ph;
	wire               pred     = chk_reg[6] ^ chk_reg[5];
	wire               rx_err   = (rxin_reg != pred) & (warm_reg == WARM_BITS);
	wire               clk_chg  = (rbc_a_next != rx_byte_clock_a) | (rbc_b_next != rx_byte_clock_b);

	// Byte clocks only move after a full minimum phase, except clock b forced low in full rate, so realignment stretches them
	always_comb
	begin
		rbc_a_next = rx_byte_clock_a;
		rbc_b_next = 1'b0;
		if (cfg_l.rate)
		begin
			if (edge_pt & ph_ok)
				rbc_a_next = 1'b1;
			else if (rx_last & ph_ok)
				rbc_a_next = 1'b0;
		end
		else
		begin
			rbc_b_next = rx_byte_clock_b;
			if (edge_pt & ph_ok)
			begin
				rbc_a_next = par_reg;
				rbc_b_next = ~par_reg;
			end
		end
	end

	always_comb
	begin
		flag_next = sync_or_pass_flag;
		if (cfg_l.prbs)
		begin
			if (!prbs_d_reg)
				flag_next = 1'b1;
			else if (cfg_l.align)
				flag_next = sync_or_pass_flag & ~rx_err;
			else
				flag_next = ~rx_err;
		end
		else if (rx_last)
			flag_next = cfg_l.align & (wsh_next[6:0] == COMMA_PAT);
	end

	always_ff @(posedge serial_clk)
	begin
		if (!lrun)
		begin
			rxin_reg          <= 1'b0;
			win_reg           <= '0;
			wsh_reg           <= IDLE_WORD;
			bcnt_reg          <= 4'h0;
			par_reg           <= 1'b1;
			chk_reg           <= '0;
			warm_reg          <= '0;
			prbs_d_reg        <= 1'b0;
			ph_reg            <= '0;
			rx_parallel_word  <= IDLE_WORD;
			rx_byte_clock_a   <= 1'b0;
			rx_byte_clock_b   <= 1'b0;
			rx_out_oe         <= 1'b0;
			sync_or_pass_flag <= 1'b0;
		end
		else
		begin
			rxin_reg          <= cfg_l.loopback ? serial_tx_pos : rx_pin;
			win_reg           <= win_next;
			wsh_reg           <= wsh_next;
			bcnt_reg          <= realign ? ALIGN_NEXT : rx_last ? 4'h0 : bcnt_reg + 4'h1;
			par_reg           <= par_reg ^ rx_last;
			chk_reg           <= {chk_reg[5:0], rxin_reg};
			warm_reg          <= !cfg_l.prbs ? 3'h0 : (warm_reg == WARM_BITS) ? warm_reg : warm_reg + 3'h1;
			prbs_d_reg        <= cfg_l.prbs;
			ph_reg            <= clk_chg ? 5'h00 : (ph_reg == PH_MAX) ? ph_reg : ph_reg + 5'h01;
			rx_byte_clock_a   <= rbc_a_next;
			rx_byte_clock_b   <= rbc_b_next;
			rx_out_oe         <= 1'b1;
			sync_or_pass_flag <= flag_next;
			if (rx_last)
				rx_parallel_word <= wsh_next;
		end
	end

	a_tx_float_loop: assert property (@(posedge serial_clk) disable iff (!lrst_s2_reg)
		cfg_l.loopback |=> !serial_tx_oe) else $error("serial outputs driven during loopback");
	a_tx_drive_norm: assert property (@(posedge serial_clk) disable iff (!lrst_s2_reg)
		lrun && !cfg_l.loopback |=> serial_tx_oe) else $error("serial outputs not driven");
	a_loop_route: assert property (@(posedge serial_clk) disable iff (!lrun)
		cfg_l.loopback ##1 lrun |-> rxin_reg == $past(serial_tx_pos)) else $error("loopback bit lost");
	a_idle_float: assert property (@(posedge serial_clk) disable iff (!lrst_s2_reg)
		!cfg_l.enable |=> !rx_out_oe && !serial_tx_oe && !rx_byte_clock_a && !rx_byte_clock_b)
		else $error("outputs active while disabled");
	a_tx_lsb_first: assert property (@(posedge serial_clk) disable iff (!lrun)
		tx_last && word_new |=> serial_tx_pos == $past(hs_data_reg[0]) ##1 serial_tx_pos == $past(hs_data_reg[1], 2))
		else $error("transmit bit order wrong");
	a_pass_live: assert property (@(posedge serial_clk) disable iff (!lrun)
		cfg_l.prbs && prbs_d_reg && !cfg_l.align |=> sync_or_pass_flag == !$past(rx_err))
		else $error("live pass flag wrong");
	a_pass_latch: assert property (@(posedge serial_clk) disable iff (!lrun)
		(cfg_l.prbs && prbs_d_reg && cfg_l.align && !sync_or_pass_flag) ##1 (cfg_l.prbs && cfg_l.align)
		|-> !sync_or_pass_flag) else $error("latched failure released");
	a_err_drops: assert property (@(posedge serial_clk) disable iff (!lrun)
		cfg_l.prbs && prbs_d_reg && rx_err |=> !sync_or_pass_flag) else $error("error not reported");
	a_full_b_low: assert property (@(posedge serial_clk) disable iff (!lrun)
		cfg_l.rate |=> !rx_byte_clock_b) else $error("clock b active in full rate");
	a_half_phase: assert property (@(posedge serial_clk) disable iff (!lrun)
		!cfg_l.rate && !$past(cfg_l.rate) && $rose(rx_byte_clock_a) |-> par_reg && !rx_byte_clock_b)
		else $error("clock a on even word");
	a_no_sliver: assert property (@(posedge serial_clk) disable iff (!lrun)
		cfg_l.rate && $past(cfg_l.rate, 5) && $fell(rx_byte_clock_a) |->
		$past(rx_byte_clock_a, 2) && $past(rx_byte_clock_a, 3) && $past(rx_byte_clock_a, 4) &&
		$past(rx_byte_clock_a, 5)) else $error("byte clock pulse shortened");
endmodule : tsts_top

/* tb/tsts_link_model.sv */
`timescale 1ns/1ps
module tsts_link_model
	import tsts_pkg::*;
(
	input  wire logic serial_clk,
	input  wire logic inject_err,
	output logic      rx_pos,
	output logic      rx_neg
);
	logic [PRBS_W-1:0] lfsr_reg = PRBS_SEED;
	logic              bit_next;

	// Same taps as the device generator so its checker can lock on; inject flips one bit
	assign bit_next = lfsr_reg[6] ^ lfsr_reg[5] ^ inject_err;

	always @(posedge serial_clk)
	begin
		lfsr_reg <= {lfsr_reg[5:0], lfsr_reg[6] ^ lfsr_reg[5]};
		rx_pos   <= bit_next;
		rx_neg   <= ~bit_next;
	end
endmodule : tsts_link_model

/* tb/tsts_top_test.sv */
`timescale 1ns/1ps
module tsts_top_test
	import tsts_pkg::*;
;
	logic              clk        = 1'b0;
	logic              serial_clk = 1'b0;
	logic              nrst       = 1'b0;
	tsts_cfg_t         cfg        = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
	logic [WORD_W-1:0] tx_word    = 10'h000;
	logic              tx_valid   = 1'b0;
	logic              inject     = 1'b0;
	logic              tx_ready, rx_pos, rx_neg, tx_pos, tx_neg, tx_oe;
	logic [WORD_W-1:0] rx_word;
	logic              bca, bcb, rx_oe, flag, pull_en;
	int                bad_count  = 0;
	int                n_tests    = 0;
	int                cycles     = 0;

	always #4 clk = ~clk;
	always #40 serial_clk = ~serial_clk;

	tsts_top DUT (.clk(clk), .nrst(nrst), .serial_clk(serial_clk), .enable(cfg.enable),
		.loopback_enable(cfg.loopback), .prbs_test_enable(cfg.prbs), .comma_align_enable(cfg.align),
		.rx_clock_rate_select(cfg.rate), .tx_parallel_word(tx_word), .tx_word_valid(tx_valid),
		.tx_word_ready(tx_ready), .serial_rx_pos(rx_pos), .serial_rx_neg(rx_neg), .serial_tx_pos(tx_pos),
		.serial_tx_neg(tx_neg), .serial_tx_oe(tx_oe), .rx_parallel_word(rx_word), .rx_byte_clock_a(bca),
		.rx_byte_clock_b(bcb), .rx_out_oe(rx_oe), .sync_or_pass_flag(flag), .input_pull_enable(pull_en));

	tsts_link_model far_end (.serial_clk(serial_clk), .inject_err(inject), .rx_pos(rx_pos), .rx_neg(rx_neg));

	task report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop

	task chk_bit(input logic got, input logic exp, input string msg);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH t=%0t %s got %b exp %b", $time, msg, got, exp);
		end
	endtask : chk_bit

	task chk_word(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp, input string msg);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk_word

	task sclk(input int n);
		repeat (n) @(negedge serial_clk);
	endtask : sclk

	task cfg_set(input tsts_cfg_t c);
		@(posedge clk);
		cfg <= c;
		sclk(8);
	endtask : cfg_set

	task send_word(input logic [WORD_W-1:0] w);
		int k;
		k = 0;
		@(posedge clk);
		tx_word  <= w;
		tx_valid <= 1'b1;
		@(posedge clk);
		while (tx_ready !== 1'b1 && k < 5000)
		begin
			@(posedge clk);
			k++;
		end
		tx_valid <= 1'b0;
		chk_bit(k < 5000, 1'b1, "word not taken");
	endtask : send_word

	task wait_rise(input logic use_b, output int n);
		logic prev;
		n = 0;
		prev = use_b ? bcb : bca;
		while (n < 40)
		begin
			sclk(1);
			n++;
			if ((use_b ? bcb : bca) === 1'b1 && prev === 1'b0)
				break;
			prev = use_b ? bcb : bca;
		end
	endtask : wait_rise

	task t_tx_order;
		logic [WORD_W-1:0] got;
		int                k;
		send_word(10'h2b5);
		k = 0;
		while (tx_pos !== 1'b1 && k < 300)
		begin
			sclk(1);
			k++;
		end
		chk_bit(tx_neg, 1'b0, "tx pair not complementary");
		for (int i = 0; i < WORD_W; i++)
		begin
			got[i] = tx_pos;
			sclk(1);
		end
		chk_word(got, 10'h2b5, "serial order");
		$display("test tx order done");
	endtask : t_tx_order

	task t_fifo_fill;
		int n;
		n = 0;
		@(posedge clk);
		tx_word  <= 10'h155;
		tx_valid <= 1'b1;
		repeat (40)
		begin
			@(posedge clk);
			if (tx_ready === 1'b1)
				n++;
		end
		tx_valid <= 1'b0;
		#1;
		chk_bit(tx_ready, 1'b0, "fifo not refusing");
		chk_bit(n >= FIFO_DEPTH && n <= FIFO_DEPTH + 2, 1'b1, "accepted count");
		sclk(140);
		chk_bit(tx_ready, 1'b1, "fifo not drained");
		$display("test fifo fill done");
	endtask : t_fifo_fill

	task t_loopback;
		logic found;
		logic sync_ok;
		cfg_set('{1'b1, 1'b1, 1'b0, 1'b1, 1'b0});
		chk_bit(tx_oe, 1'b0, "tx driven in loopback");
		repeat (3)
		begin
			repeat (3) send_word(10'h17c);
			send_word(10'h2a5);
		end
		found = 1'b0;
		sync_ok = 1'b0;
		for (int i = 0; i < 400 && !found; i++)
		begin
			sclk(1);
			if (rx_word === 10'h17c && flag === 1'b1)
				sync_ok = 1'b1;
			if (rx_word === 10'h2a5)
				found = 1'b1;
		end
		chk_bit(found, 1'b1, "looped word missing");
		chk_bit(sync_ok, 1'b1, "comma sync flag");
		$display("test loopback done");
	endtask : t_loopback

	task t_rates;
		int n;
		cfg_set('{1'b1, 1'b1, 1'b0, 1'b1, 1'b1});
		sclk(30);
		wait_rise(1'b0, n);
		wait_rise(1'b0, n);
		chk_bit(n == 10, 1'b1, "full rate period");
		wait_rise(1'b1, n);
		chk_bit(n == 40, 1'b1, "clock b not held low");
		cfg_set('{1'b1, 1'b1, 1'b0, 1'b1, 1'b0});
		sclk(30);
		wait_rise(1'b0, n);
		wait_rise(1'b0, n);
		chk_bit(n == 20, 1'b1, "half rate period");
		wait_rise(1'b1, n);
		chk_bit(n == 10, 1'b1, "clocks not alternating");
		$display("test rates done");
	endtask : t_rates

	task t_prbs;
		int ones;
		int errs;
		logic [39:0] b;
		logic low_seen;
		cfg_set('{1'b1, 1'b0, 1'b1, 1'b0, 1'b0});
		@(posedge clk);
		tx_valid <= 1'b1;
		sclk(20);
		for (int i = 0; i < 40; i++)
		begin
			b[i] = tx_pos;
			sclk(1);
		end
		@(posedge clk);
		tx_valid <= 1'b0;
		ones = 0;
		errs = 0;
		for (int i = 0; i < 40; i++)
		begin
			ones += b[i];
			if (i >= 7 && b[i] !== (b[i-6] ^ b[i-7]))
				errs++;
		end
		chk_bit(errs == 0 && ones > 0, 1'b1, "pattern sequence");
		sclk(20);
		chk_bit(flag, 1'b1, "pattern not passing");
		@(posedge serial_clk) inject <= 1'b1;
		@(posedge serial_clk) inject <= 1'b0;
		low_seen = 1'b0;
		repeat (12)
		begin
			sclk(1);
			low_seen |= (flag === 1'b0);
		end
		chk_bit(low_seen, 1'b1, "error not flagged");
		sclk(30);
		chk_bit(flag, 1'b1, "live flag not recovered");
		cfg_set('{1'b1, 1'b0, 1'b0, 1'b1, 1'b0});
		cfg_set('{1'b1, 1'b0, 1'b1, 1'b1, 1'b0});
		sclk(30);
		chk_bit(flag, 1'b1, "latched pass");
		@(posedge serial_clk) inject <= 1'b1;
		@(posedge serial_clk) inject <= 1'b0;
		sclk(60);
		chk_bit(flag, 1'b0, "failure not latched");
		$display("test prbs done");
	endtask : t_prbs

	task t_enable;
		cfg_set('{1'b0, 1'b0, 1'b0, 1'b0, 1'b0});
		sclk(4);
		chk_bit(tx_oe, 1'b0, "tx driven when off");
		chk_bit(rx_oe, 1'b0, "rx driven when off");
		chk_bit(pull_en, 1'b0, "pulls on when off");
		cfg_set('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0});
		sclk(4);
		chk_bit(rx_oe, 1'b1, "rx not driven");
		$display("test enable done");
	endtask : t_enable

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			bad_count++;
			$display("MISMATCH t=%0t run timed out", $time);
			report_and_stop();
		end
	end

	initial
	begin
		repeat (9) @(posedge clk);
		@(negedge clk);
		chk_bit(tx_ready, 1'b0, "ready in reset");
		@(posedge clk);
		nrst <= 1'b1;
		// Link side leaves reset three of its own edges later: two for the reset synchronizer, one for enable capture
		sclk(3);
		chk_bit(tx_oe, 1'b0, "tx driven in reset");
		sclk(10);
		chk_bit(tx_oe, 1'b1, "tx not driven");
		chk_bit(pull_en, 1'b1, "pulls off");
		t_tx_order();
		t_fifo_fill();
		t_loopback();
		t_rates();
		t_prbs();
		t_enable();
		report_and_stop();
	end
endmodule : tsts_top_test
